// file: sie_pkg.sv
// Shared constants and types of the special instruction execution block
`default_nettype none
package sie_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_OPND = 8'h08;
  localparam logic [7:0] OFS_INSTR = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  // Instruction word fields
  localparam int F_OP = 0;
  localparam int F_LEN = 4;
  localparam int F_MODE = 6;
  localparam int F_BIT = 8;
  localparam int F_IMM = 10;
  localparam int F_MEM = 18;
  // Control, state and result fields
  localparam int F_MBE = 0;
  localparam int F_MBS = 4;
  localparam int F_X = 4;
  localparam int F_CY = 8;
  localparam int F_HL = 16;
  localparam int F_RBIT = 12;
  localparam int F_RNIB = 16;
  localparam int F_TADDR = 24;
  // Table-indirect execute table
  localparam logic [6:0] TBL_BASE = 7'h20;
  localparam logic [6:0] TBL_LAST = 7'h7F;
  localparam logic [7:0] TBL_ENTRIES = 8'h30;
  // Bit addressing windows
  localparam logic [11:0] FMEM_LO0 = 12'hFB0;
  localparam logic [11:0] FMEM_HI0 = 12'hFBF;
  localparam logic [11:0] FMEM_LO1 = 12'hFF0;
  localparam logic [11:0] PMEM_LO = 12'hFC0;
  localparam logic [11:0] MEM_TOP = 12'hFFF;
  // Machine cycle costs
  localparam logic [1:0] MC_SKIP_LONG = 2'd2;
  localparam logic [1:0] MC_SKIP_SHORT = 2'd1;
  localparam logic [1:0] LEN_LONG = 2'd3;
  localparam int MC_CLKS = 4;
  // Reset values
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_MOV_A_N4 = 4'h1, OP_MOV_XA_N8 = 4'h2, OP_MOV_HL_N8 = 4'h3,
    OP_ADD_IMMEDIATE_SKIP = 4'h4, OP_ADD_WITH_CARRY = 4'h5, OP_SUBTRACT_WITH_BORROW = 4'h6, OP_BSET = 4'h7,
    OP_BCLR = 4'h8, OP_BTST = 4'h9, OP_BAND = 4'hA, OP_BOR = 4'hB,
    OP_BXOR = 4'hC, OP_BMOV = 4'hD, OP_TABLE_INDIRECT_EXECUTE = 4'hE, OP_BLOCK_RELATIVE_BRANCH_FIXED_AREA_CALL = 4'hF
  } sie_op_t;

  typedef enum logic [1:0] {
    GRP_NONE = 2'd0, GRP_ACC = 2'd1, GRP_HL = 2'd2
  } sie_grp_t;

  typedef enum logic [1:0] {
    BM_FMEM = 2'd0, BM_PMEM_L = 2'd1, BM_H_MEM = 2'd2
  } sie_bmode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01
  } sie_state_t;
endpackage
`default_nettype wire

// file: sie_bit_addr.sv
// Effective bit address for the three bit manipulation addressing modes
`default_nettype none
module sie_bit_addr (
  input wire logic [1:0] mode,
  input wire logic [11:0] mem_addr,
  input wire logic [1:0] bit_imm,
  input wire logic [7:0] hl,
  input wire logic bank_enable_flag,
  input wire logic [3:0] bank_select_register,
  output logic [11:0] eff_addr,
  output logic [1:0] eff_bit,
  output logic valid
);
  logic [3:0] bank;
  logic in_fmem;
  logic in_pmem;
  logic [11:0] pmem_addr;

  assign bank = bank_enable_flag ? bank_select_register : 4'h0; // RULE_07
  assign in_fmem = ((mem_addr >= sie_pkg::FMEM_LO0) && (mem_addr <= sie_pkg::FMEM_HI0)) ||
                   (mem_addr >= sie_pkg::FMEM_LO1); // RULE_05
  assign pmem_addr = {mem_addr[11:2], 2'b00};
  assign in_pmem = (pmem_addr >= sie_pkg::PMEM_LO); // RULE_06

  assign eff_addr = (mode == sie_pkg::BM_FMEM) ? mem_addr :
                    (mode == sie_pkg::BM_PMEM_L) ? pmem_addr :
                    {bank, hl[7:4], mem_addr[3:0]}; // RULE_07
  assign eff_bit = (mode == sie_pkg::BM_PMEM_L) ? hl[1:0] : bit_imm; // RULE_06
  assign valid = (mode == sie_pkg::BM_FMEM) ? in_fmem :
                 (mode == sie_pkg::BM_PMEM_L) ? in_pmem :
                 (mode == sie_pkg::BM_H_MEM);
endmodule
`default_nettype wire

// file: sie_core.sv
// Special instruction execution unit with AHB-Lite register slave
// How it works
// RULE_01 - Table execute is one byte, fetching a two-byte entry from 0020H-007FH.
// RULE_02 - Entry may be call, branch, two-cycle instruction or pair; not block branches.
// RULE_03 - Exactly 48 table entries are selectable by the one-byte execute.
// RULE_04 - Bit test, transfer, AND, OR, XOR, set and clear on single bits.
// RULE_05 - Short direct bit mode reaches FB0H-FBFH and FF0H-FFFH.
// RULE_06 - Pointer-low indirect bit mode reaches FC0H-FFFH, bit taken from L.
// RULE_07 - Pointer-high bit mode uses active bank, enable flag ANDed with bank select.
// RULE_08 - Accumulator immediates form one string group, pointer immediate another.
// RULE_09 - Consecutive same-group loads after the first one run as no-operations.
// RULE_10 - Add with carry puts A plus memory plus carry in A, carry out in CY.
// RULE_11 - Base-m add: add 16-m, add with carry, add m; CY flags overflow.
// RULE_12 - Carry from add with carry skips the next immediate add.
// RULE_13 - Immediate add right after add/subtract with carry never raises a skip.
// RULE_14 - Subtract with borrow skips next immediate add unless it borrows; CY is underflow.
// RULE_15 - A met skip condition drops the next instruction and continues after it.
// RULE_16 - Skipping a three-byte branch or call costs two machine cycles.
// RULE_17 - Skipping any other instruction costs one machine cycle.
// RULE_18 - Skipping the table execute instruction costs one machine cycle.
// RULE_19 - A string run ends at the first instruction of another group.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`default_nettype none
module sie_core #(
  parameter int MC_CLKS = sie_pkg::MC_CLKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic busy
);
  // Bus slave
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic take_ap;
  logic [31:0] rd_mux;

  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
  assign take_ap = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Architectural state
  logic [3:0] acc_q, acc_d;
  logic [3:0] x_q, x_d;
  logic cy_q, cy_d;
  logic [7:0] hl_q, hl_d;
  logic mbe_q;
  logic [3:0] mbs_q;
  logic [3:0] opnd_q;
  logic [31:0] instr_q;
  logic skip_q, skip_d;
  logic adj_q, adj_d;
  logic table_indirect_execute_q, table_indirect_execute_d;
  sie_pkg::sie_grp_t grp_q, grp_d;
  logic skipped_q, skipped_d;
  logic nop_q, nop_d;
  logic refused_q, refused_d;
  logic [1:0] cost_q, cost_d;
  logic [11:0] eaddr_q;
  logic [1:0] ebit_q;
  logic [3:0] rnib_q, rnib_d;
  logic [6:0] taddr_q, taddr_d;
  logic bvalid_q;

  // Instruction decode
  logic wr_ctrl, wr_state, wr_opnd, wr_instr, take;
  sie_pkg::sie_op_t op;
  sie_pkg::sie_grp_t op_grp;
  logic [1:0] len;
  logic [7:0] imm;
  logic is_bitop, str_nop, bad_table_indirect_execute, bad_entry, bad_bit, refuse;
  logic [11:0] eff_addr;
  logic [1:0] eff_bit;
  logic bit_valid, bit_val;
  logic [4:0] add_sum, sub_dif, add_immediate_skip_sum;
  logic [7:0] tbl_off;
  logic [1:0] skip_cost, exec_cost;

  assign wr_ctrl = wr_pend_q && (wr_addr_q == sie_pkg::OFS_CTRL);
  assign wr_state = wr_pend_q && (wr_addr_q == sie_pkg::OFS_STATE) && !busy;
  assign wr_opnd = wr_pend_q && (wr_addr_q == sie_pkg::OFS_OPND);
  assign wr_instr = wr_pend_q && (wr_addr_q == sie_pkg::OFS_INSTR);
  assign take = wr_instr && !busy;

  assign op = sie_pkg::sie_op_t'(hwdata[sie_pkg::F_OP +: 4]);
  assign len = hwdata[sie_pkg::F_LEN +: 2];
  assign imm = hwdata[sie_pkg::F_IMM +: 8];
  assign op_grp = ((op == sie_pkg::OP_MOV_A_N4) || (op == sie_pkg::OP_MOV_XA_N8)) ?
                  sie_pkg::GRP_ACC :
                  (op == sie_pkg::OP_MOV_HL_N8) ? sie_pkg::GRP_HL : sie_pkg::GRP_NONE; // RULE_08
  assign str_nop = (op_grp != sie_pkg::GRP_NONE) && (op_grp == grp_q); // RULE_09
  assign is_bitop = (op >= sie_pkg::OP_BSET) && (op <= sie_pkg::OP_BMOV);
  assign bad_table_indirect_execute = (op == sie_pkg::OP_TABLE_INDIRECT_EXECUTE) && (imm >= sie_pkg::TBL_ENTRIES); // RULE_03
  assign bad_entry = table_indirect_execute_q && ((op == sie_pkg::OP_BLOCK_RELATIVE_BRANCH_FIXED_AREA_CALL) ||
                                (op == sie_pkg::OP_TABLE_INDIRECT_EXECUTE)); // RULE_02
  assign bad_bit = is_bitop && !bit_valid;
  assign refuse = bad_table_indirect_execute || bad_entry || bad_bit;
  assign tbl_off = {imm[6:0], 1'b0};
  assign bit_val = opnd_q[eff_bit];
  assign add_sum = {1'b0, acc_q} + {1'b0, opnd_q} + {4'h0, cy_q}; // RULE_10
  assign sub_dif = {1'b0, acc_q} - {1'b0, opnd_q} - {4'h0, cy_q}; // RULE_14
  assign add_immediate_skip_sum = {1'b0, acc_q} + {1'b0, imm[3:0]}; // RULE_11
  assign skip_cost = ((len == sie_pkg::LEN_LONG) && (op != sie_pkg::OP_TABLE_INDIRECT_EXECUTE)) ?
                     sie_pkg::MC_SKIP_LONG : sie_pkg::MC_SKIP_SHORT; // RULE_16 RULE_17 RULE_18
  assign exec_cost = ((len == 2'd0) || (op == sie_pkg::OP_TABLE_INDIRECT_EXECUTE)) ? 2'd1 : len; // RULE_01

  sie_bit_addr u_bit_addr (
    .mode(hwdata[sie_pkg::F_MODE +: 2]),
    .mem_addr(hwdata[sie_pkg::F_MEM +: 12]),
    .bit_imm(hwdata[sie_pkg::F_BIT +: 2]),
    .hl(hl_q),
    .bank_enable_flag(mbe_q),
    .bank_select_register(mbs_q),
    .eff_addr(eff_addr),
    .eff_bit(eff_bit),
    .valid(bit_valid)
  );

  always_comb begin
    acc_d = acc_q;
    x_d = x_q;
    cy_d = cy_q;
    hl_d = hl_q;
    skip_d = skip_q;
    adj_d = adj_q;
    table_indirect_execute_d = table_indirect_execute_q;
    grp_d = grp_q;
    skipped_d = skipped_q;
    nop_d = nop_q;
    refused_d = refused_q;
    cost_d = cost_q;
    rnib_d = rnib_q;
    taddr_d = taddr_q;
    if (wr_state) begin
      acc_d = hwdata[3:0];
      x_d = hwdata[sie_pkg::F_X +: 4];
      cy_d = hwdata[sie_pkg::F_CY];
      hl_d = hwdata[sie_pkg::F_HL +: 8];
    end
    if (take) begin
      skipped_d = 1'b0;
      nop_d = 1'b0;
      refused_d = 1'b0;
      skip_d = 1'b0;
      adj_d = 1'b0;
      table_indirect_execute_d = 1'b0;
      cost_d = exec_cost;
      rnib_d = opnd_q;
      if (skip_q) begin
        skipped_d = 1'b1; // RULE_15
        grp_d = sie_pkg::GRP_NONE;
        cost_d = skip_cost; // RULE_16 RULE_17 RULE_18
      end else if (refuse) begin
        refused_d = 1'b1;
        cost_d = 2'd1;
        grp_d = sie_pkg::GRP_NONE;
      end else begin
        grp_d = op_grp; // RULE_19
        if (str_nop) begin
          nop_d = 1'b1; // RULE_09
          cost_d = 2'd1;
        end else begin
          case (op)
            sie_pkg::OP_MOV_A_N4: begin
              acc_d = imm[3:0];
            end
            sie_pkg::OP_MOV_XA_N8: begin
              acc_d = imm[3:0];
              x_d = imm[7:4];
            end
            sie_pkg::OP_MOV_HL_N8: begin
              hl_d = imm;
            end
            sie_pkg::OP_ADD_IMMEDIATE_SKIP: begin
              acc_d = add_immediate_skip_sum[3:0];
              skip_d = add_immediate_skip_sum[4] && !adj_q; // RULE_13
            end
            sie_pkg::OP_ADD_WITH_CARRY: begin
              acc_d = add_sum[3:0]; // RULE_10
              cy_d = add_sum[4];
              skip_d = add_sum[4]; // RULE_12
              adj_d = 1'b1;
            end
            sie_pkg::OP_SUBTRACT_WITH_BORROW: begin
              acc_d = sub_dif[3:0];
              cy_d = sub_dif[4];
              skip_d = !sub_dif[4]; // RULE_14
              adj_d = 1'b1;
            end
            sie_pkg::OP_BSET: begin
              rnib_d = opnd_q | (4'h1 << eff_bit); // RULE_04
            end
            sie_pkg::OP_BCLR: begin
              rnib_d = opnd_q & ~(4'h1 << eff_bit); // RULE_04
            end
            sie_pkg::OP_BTST: begin
              skip_d = bit_val; // RULE_04
            end
            sie_pkg::OP_BAND: begin
              cy_d = cy_q & bit_val; // RULE_04
            end
            sie_pkg::OP_BOR: begin
              cy_d = cy_q | bit_val; // RULE_04
            end
            sie_pkg::OP_BXOR: begin
              cy_d = cy_q ^ bit_val; // RULE_04
            end
            sie_pkg::OP_BMOV: begin
              cy_d = bit_val; // RULE_04
            end
            sie_pkg::OP_TABLE_INDIRECT_EXECUTE: begin
              taddr_d = sie_pkg::TBL_BASE + tbl_off[6:0]; // RULE_01
              table_indirect_execute_d = 1'b1;
            end
            default: begin
              nop_d = 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Machine cycle divider and busy sequencer
  sie_pkg::sie_state_t state_q;
  logic [7:0] div_q;
  logic [1:0] left_q;
  logic mc_tick;

  assign mc_tick = (state_q == sie_pkg::ST_RUN) && (div_q == 8'(MC_CLKS - 1));
  assign busy = (state_q == sie_pkg::ST_RUN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= sie_pkg::ST_IDLE;
      div_q <= sie_pkg::RST_BYTE;
      left_q <= 2'd0;
    end else begin
      case (state_q)
        sie_pkg::ST_IDLE: begin
          div_q <= sie_pkg::RST_BYTE;
          if (take) begin
            state_q <= sie_pkg::ST_RUN;
            left_q <= cost_d;
          end
        end
        sie_pkg::ST_RUN: begin
          div_q <= mc_tick ? sie_pkg::RST_BYTE : div_q + 8'd1;
          if (mc_tick) begin
            left_q <= left_q - 2'd1;
            if (left_q == 2'd1) begin
              state_q <= sie_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= sie_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= sie_pkg::RST_NIB;
      x_q <= sie_pkg::RST_NIB;
      cy_q <= 1'b0;
      hl_q <= sie_pkg::RST_BYTE;
      skip_q <= 1'b0;
      adj_q <= 1'b0;
      table_indirect_execute_q <= 1'b0;
      grp_q <= sie_pkg::GRP_NONE;
      skipped_q <= 1'b0;
      nop_q <= 1'b0;
      refused_q <= 1'b0;
      cost_q <= 2'd0;
      rnib_q <= sie_pkg::RST_NIB;
      taddr_q <= 7'h00;
    end else begin
      acc_q <= acc_d;
      x_q <= x_d;
      cy_q <= cy_d;
      hl_q <= hl_d;
      skip_q <= skip_d;
      adj_q <= adj_d;
      table_indirect_execute_q <= table_indirect_execute_d;
      grp_q <= grp_d;
      skipped_q <= skipped_d;
      nop_q <= nop_d;
      refused_q <= refused_d;
      cost_q <= cost_d;
      rnib_q <= rnib_d;
      taddr_q <= taddr_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mbe_q <= 1'b0;
      mbs_q <= sie_pkg::RST_NIB;
      opnd_q <= sie_pkg::RST_NIB;
      instr_q <= 32'h00000000;
      eaddr_q <= 12'h000;
      ebit_q <= 2'd0;
      bvalid_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mbe_q <= hwdata[sie_pkg::F_MBE];
        mbs_q <= hwdata[sie_pkg::F_MBS +: 4];
      end
      if (wr_opnd) begin
        opnd_q <= hwdata[3:0];
      end
      if (take) begin
        instr_q <= hwdata;
        eaddr_q <= eff_addr;
        ebit_q <= eff_bit;
        bvalid_q <= bit_valid;
      end
    end
  end

  // Read mux and bus phase tracking
  assign rd_mux = (haddr[7:0] == sie_pkg::OFS_CTRL) ? {24'h0, mbs_q, 3'h0, mbe_q} :
                  (haddr[7:0] == sie_pkg::OFS_STATE) ?
                    {8'h00, hl_q, 7'h00, cy_q, x_q, acc_q} :
                  (haddr[7:0] == sie_pkg::OFS_OPND) ? {28'h0, opnd_q} :
                  (haddr[7:0] == sie_pkg::OFS_INSTR) ? instr_q :
                  (haddr[7:0] == sie_pkg::OFS_STATUS) ?
                    {21'h0, bvalid_q, cost_q, grp_q, refused_q, nop_q, skipped_q,
                     adj_q, skip_q, busy} :
                  (haddr[7:0] == sie_pkg::OFS_RESULT) ?
                    {1'b0, taddr_q, 4'h0, rnib_q, 2'b00, ebit_q, eaddr_q} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= take_ap && hwrite && addr_ok;
      if (take_ap) begin
        wr_addr_q <= haddr[7:0];
        hrdata_q <= (!hwrite && addr_ok) ? rd_mux : 32'h00000000;
      end
    end
  end

  // Checks
  property p_add_with_carry_sum;
    @(posedge hclk) disable iff (!hresetn)
      (take && !skip_q && op == sie_pkg::OP_ADD_WITH_CARRY) |=> ({cy_q, acc_q} == $past(add_sum));
  endproperty
  a_add_with_carry_sum: assert property (p_add_with_carry_sum) else $error("add with carry result wrong"); // RULE_10

  property p_add_with_carry_skip;
    @(posedge hclk) disable iff (!hresetn)
      (take && !skip_q && op == sie_pkg::OP_ADD_WITH_CARRY) |=> (skip_q == cy_q);
  endproperty
  a_add_with_carry_skip: assert property (p_add_with_carry_skip) else $error("carry skip not armed"); // RULE_12

  property p_subtract_with_borrow_skip;
    @(posedge hclk) disable iff (!hresetn)
      (take && !skip_q && op == sie_pkg::OP_SUBTRACT_WITH_BORROW) |=> (skip_q == !cy_q);
  endproperty
  a_subtract_with_borrow_skip: assert property (p_subtract_with_borrow_skip) else $error("borrow skip wrong"); // RULE_14

  property p_add_immediate_skip_noskip;
    @(posedge hclk) disable iff (!hresetn)
      (take && !skip_q && adj_q && op == sie_pkg::OP_ADD_IMMEDIATE_SKIP) |=> !skip_q;
  endproperty
  a_add_immediate_skip_noskip: assert property (p_add_immediate_skip_noskip) else $error("adjust add raised skip"); // RULE_13

  property p_str_nop;
    @(posedge hclk) disable iff (!hresetn)
      (take && !skip_q && !refuse && str_nop) |=> ($stable(acc_q) && $stable(hl_q) && nop_q);
  endproperty
  a_str_nop: assert property (p_str_nop) else $error("string load not suppressed"); // RULE_09

  property p_skip_state;
    @(posedge hclk) disable iff (!hresetn)
      (take && skip_q) |=> (skipped_q && !skip_q && $stable(acc_q) && $stable(cy_q));
  endproperty
  a_skip_state: assert property (p_skip_state) else $error("skipped instruction acted"); // RULE_15

  property p_skip_long;
    @(posedge hclk) disable iff (!hresetn)
      (take && skip_q && len == sie_pkg::LEN_LONG && op != sie_pkg::OP_TABLE_INDIRECT_EXECUTE)
        |=> (busy && left_q == 2'd2);
  endproperty
  a_skip_long: assert property (p_skip_long) else $error("long skip cost wrong"); // RULE_16

  property p_skip_short;
    @(posedge hclk) disable iff (!hresetn)
      (take && skip_q && (len != sie_pkg::LEN_LONG || op == sie_pkg::OP_TABLE_INDIRECT_EXECUTE))
        |=> (left_q == 2'd1) ##0 busy [*1] ##[1:64] !busy;
  endproperty
  a_skip_short: assert property (p_skip_short) else $error("short skip cost wrong"); // RULE_17

  property p_tbl_range;
    @(posedge hclk) disable iff (!hresetn)
      (take && !skip_q && !refuse && op == sie_pkg::OP_TABLE_INDIRECT_EXECUTE)
        |=> (taddr_q >= sie_pkg::TBL_BASE && taddr_q < sie_pkg::TBL_LAST && !taddr_q[0]);
  endproperty
  a_tbl_range: assert property (p_tbl_range) else $error("table address out of range"); // RULE_01

  property p_bank;
    @(posedge hclk) disable iff (!hresetn)
      (take && hwdata[sie_pkg::F_MODE +: 2] == sie_pkg::BM_H_MEM)
        |-> (eff_addr[11:8] == (mbe_q ? mbs_q : 4'h0));
  endproperty
  a_bank: assert property (p_bank) else $error("active bank wrong"); // RULE_07

  c_base_adjust: cover property (@(posedge hclk) disable iff (!hresetn)
    (take && op == sie_pkg::OP_ADD_WITH_CARRY) ##[1:64] (take && op == sie_pkg::OP_ADD_IMMEDIATE_SKIP && skip_q));
  c_string_run: cover property (@(posedge hclk) disable iff (!hresetn)
    (take && str_nop && !skip_q));
  c_long_skip: cover property (@(posedge hclk) disable iff (!hresetn)
    (take && skip_q && len == sie_pkg::LEN_LONG));
endmodule
`default_nettype wire

// file: sie_core_test.sv
// Self-checking bench for the special instruction execution unit
`default_nettype none
module sie_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MC = 2;
  localparam logic [19:0] ADJ [4] = '{20'h75623, 20'h23650, 20'h35086, 20'h53025};
  localparam logic [11:0] BOPS [6] = '{12'h740, 12'h800, 12'hA40, 12'hB41, 12'hC40, 12'hD41};
  localparam logic [31:0] AMD [6] = '{32'h0FF71FF7, 32'h0F000000, 32'h1FC41000, 32'h1F800000,
    32'h20051F35, 32'h60051035};
  localparam logic [11:0] SKP [3] = '{12'h032, 12'hE11, 12'h021};
  logic hclk, hresetn, hsel, hwrite, busy, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] eq[$], mq[$];
  int bq[$];
  int errors = 0;
  int checked = 0;
  int bc = 0;
  logic rd_ph = 1'b0;

  sie_core #(.MC_CLKS(MC)) sie_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Read data and busy length checker
  always @(posedge hclk) begin
    if (rd_ph) cmp(hrdata & mq.pop_front(), eq.pop_front());
    if (rd_ph) cmp({31'h0, hresp}, 32'h0);
    rd_ph = hsel && htrans[1] && !hwrite && hreadyout;
    if (busy === 1'b1) bc++;
    else if (bc != 0) begin
      if (bq[0] != 0) cmp(32'(bc), 32'(bq[0]));
      void'(bq.pop_front());
      bc = 0;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [31:0] ins(input logic [3:0] op, input logic [1:0] ln,
      input logic [1:0] md, input logic [1:0] b, input logic [7:0] imm, input logic [11:0] m);
    return {2'h0, m, imm, b, md, ln, op};
  endfunction

  // Bounded wait for hready or for busy to drop
  task automatic wt(input bit on_busy);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 200) begin
        errors++;
        print_verdict();
      end
    end while (on_busy ? busy !== 1'b0 : hreadyout !== 1'b1);
  endtask

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wt(0);
    htrans <= 2'b00;
    hwdata <= d;
    wt(0);
  endtask

  // Idle cycle after a write so a following read sees the new value
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    wt(0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e & m);
    mq.push_back(m);
    xfer(a, 1'b0, 32'h0);
  endtask

  // Issue one instruction; cost zero leaves its busy length unchecked
  task automatic iss(input logic [31:0] w, input int cost);
    bq.push_back(cost * MC);
    xfer(32'h0C, 1'b1, w);
    wt(1);
  endtask

  initial begin
    logic [31:0] r;
    logic [3:0] a, m;
    logic [4:0] sum;
    logic c;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rnd = 32'hA19BDDD0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, read-only and unmapped places
    wr(32'h14, 32'hFFFFFFFF);
    wr(32'h18, 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) rd(32'(i * 4), 32'h0, 32'hFFFFFFFF);
    wr(32'h00, 32'hF1);
    rd(32'h00, 32'hF1, 32'hFF);
    // Random add with carry, then a following instruction
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      a = rnd[3:0];
      m = rnd[7:4];
      c = rnd[8];
      sum = a + m + c;
      wr(32'h04, {23'h0, c, 4'h0, a});
      wr(32'h08, {28'h0, m});
      iss(ins(sie_pkg::OP_ADD_WITH_CARRY, 2'd1, 2'd0, 2'd0, 8'h0, 12'h0), 1);
      rd(32'h04, {23'h0, sum[4], 4'h0, sum[3:0]}, 32'h10F);
      rd(32'h10, {29'h0, 1'b1, sum[4], 1'b0}, 32'h6);
      iss(ins(sie_pkg::OP_NOP, 2'd1, 2'd0, 2'd0, 8'h0, 12'h0), 1);
      rd(32'h10, {22'h0, 2'd1, 4'h0, sum[4], 3'h0}, 32'h308);
    end
    // Base adjustment sequences
    for (int i = 0; i < 4; i++) begin
      r = 32'(ADJ[i]);
      wr(32'h04, {28'h0, r[19:16]});
      wr(32'h08, {28'h0, r[15:12]});
      if (r[11:8] != 4'h0) iss(ins(sie_pkg::OP_ADD_IMMEDIATE_SKIP, 2'd1, 2'd0, 2'd0, {4'h0, r[11:8]}, 12'h0), 1);
      iss(ins(r[2] ? sie_pkg::OP_SUBTRACT_WITH_BORROW : sie_pkg::OP_ADD_WITH_CARRY, 2'd1, 2'd0, 2'd0, 8'h0, 12'h0), 1);
      iss(ins(sie_pkg::OP_ADD_IMMEDIATE_SKIP, 2'd1, 2'd0, 2'd0, 8'h0A, 12'h0), 1);
      rd(32'h04, {23'h0, r[1], 4'h0, r[7:4]}, 32'h10F);
      rd(32'h10, {28'h0, r[0], 3'h0}, 32'h8);
      iss(ins(sie_pkg::OP_NOP, 2'd1, 2'd0, 2'd0, 8'h0, 12'h0), 1);
      rd(32'h10, 32'h0, 32'h8);
    end
    // String-effect runs
    iss(ins(sie_pkg::OP_MOV_A_N4, 2'd1, 2'd0, 2'd0, 8'h01, 12'h0), 1);
    iss(ins(sie_pkg::OP_MOV_A_N4, 2'd1, 2'd0, 2'd0, 8'h05, 12'h0), 0);
    rd(32'h10, 32'h10, 32'h10);
    iss(ins(sie_pkg::OP_MOV_XA_N8, 2'd2, 2'd0, 2'd0, 8'h77, 12'h0), 0);
    iss(ins(sie_pkg::OP_MOV_HL_N8, 2'd2, 2'd0, 2'd0, 8'h37, 12'h0), 2);
    iss(ins(sie_pkg::OP_MOV_HL_N8, 2'd2, 2'd0, 2'd0, 8'h12, 12'h0), 0);
    iss(ins(sie_pkg::OP_MOV_A_N4, 2'd1, 2'd0, 2'd0, 8'h09, 12'h0), 1);
    rd(32'h04, 32'h00370009, 32'hFF000F);
    // Table execute bounds and forbidden entries
    iss(ins(sie_pkg::OP_TABLE_INDIRECT_EXECUTE, 2'd1, 2'd0, 2'd0, 8'd0, 12'h0), 1);
    rd(32'h14, 32'h20000000, 32'h7F000000);
    iss(ins(sie_pkg::OP_NOP, 2'd1, 2'd0, 2'd0, 8'h0, 12'h0), 1);
    iss(ins(sie_pkg::OP_TABLE_INDIRECT_EXECUTE, 2'd1, 2'd0, 2'd0, 8'd47, 12'h0), 1);
    rd(32'h14, 32'h7E000000, 32'h7F000000);
    iss(ins(sie_pkg::OP_BLOCK_RELATIVE_BRANCH_FIXED_AREA_CALL, 2'd2, 2'd0, 2'd0, 8'h0, 12'h0), 1);
    rd(32'h10, 32'h20, 32'h20);
    iss(ins(sie_pkg::OP_TABLE_INDIRECT_EXECUTE, 2'd1, 2'd0, 2'd0, 8'd48, 12'h0), 1);
    rd(32'h10, 32'h20, 32'h20);
    iss(ins(sie_pkg::OP_NOP, 2'd1, 2'd0, 2'd0, 8'h0, 12'h0), 1);
    // Bit operations on one short direct bit
    wr(32'h04, 32'h00370000);
    wr(32'h08, 32'h4);
    for (int i = 0; i < 6; i++) begin
      iss(ins(BOPS[i][11:8], 2'd2, 2'd0, 2'd2, 8'h0, 12'hFB3), 2);
      rd(32'h14, {12'h0, BOPS[i][7:4], 2'h0, 2'd2, 12'hFB3}, 32'h000F3FFF);
      rd(32'h04, {23'h0, BOPS[i][0], 8'h0}, 32'h100);
    end
    // Bit addressing modes and windows
    for (int i = 0; i < 6; i++) begin
      r = AMD[i];
      if (r[30]) wr(32'h00, 32'hF0);
      iss(ins(sie_pkg::OP_BSET, 2'd2, r[29:28], 2'd0, 8'h0, r[27:16]), r[12] ? 2 : 1);
      rd(32'h10, {21'h0, r[12], 10'h0}, 32'h400);
      if (r[11:0] != 12'h0) rd(32'h14, {20'h0, r[11:0]}, 32'hFFF);
    end
    // Skip cost by kind of skipped instruction
    for (int i = 0; i < 3; i++) begin
      r = 32'(SKP[i]);
      iss(ins(sie_pkg::OP_BTST, 2'd2, 2'd0, 2'd2, 8'h0, 12'hFB3), 2);
      rd(32'h10, 32'h2, 32'h2);
      iss(ins(r[11:8], r[5:4], 2'd0, 2'd0, 8'd47, 12'h0), int'(r[1:0]));
      rd(32'h10, {22'h0, r[1:0], 4'h0, 1'b1, 3'h0}, 32'h308);
    end
    repeat (3) @(posedge hclk);
    cmp(32'(eq.size() + bq.size()), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
